// ==== src/cap_consts.svh ====
// Constants for the card authentication and PIN command handler
`ifndef CAP_CONSTS_SVH
`define CAP_CONSTS_SVH

`define CAP_CLA_PLAIN 8'h00
`define CAP_CLA_SM_MAC 8'h8c
`define CAP_CLA_SM_ALT 8'h84
`define CAP_INS_AUTH 8'h88
`define CAP_INS_PIN 8'h24
`define CAP_P_ZERO 8'h00
`define CAP_P2_PIN_MAX 8'h02
`define CAP_LE_VALUE 8'h00
`define CAP_TAG_PRIM 8'h80
`define CAP_TAG_CONS 8'h79
`define CAP_TAG_HDR_LEN 8'h02

`define CAP_SW_OK 16'h9000
`define CAP_SW1_WARN 8'h62
`define CAP_SW_WARN_NONE 16'h6200
`define CAP_SW_WARN_CORRUPT 16'h6281
`define CAP_SW_NVM_SAME 16'h6400
`define CAP_SW_MEM_FAIL 16'h6581
`define CAP_SW_NO_LE 16'h6700
`define CAP_SW_SM_UNSUP 16'h6882
`define CAP_SW_SEC_UNMET 16'h6982
`define CAP_SW_REF_INVAL 16'h6984
`define CAP_SW_COND_UNMET 16'h6985
`define CAP_SW_SM_MISSING 16'h6987
`define CAP_SW_SM_WRONG 16'h6988
`define CAP_SW_BAD_DATA 16'h6a80
`define CAP_SW_BAD_P1P2 16'h6a86
`define CAP_SW_REF_ABSENT 16'h6a88
`define CAP_SW_BAD_INS 16'h6d00
`define CAP_SW_BAD_CLA 16'h6e00

`define CAP_SM_BITS_HI 3
`define CAP_SM_BITS_LO 2
`define CAP_PTC_W 4
`define CAP_PTC_RST 4'h3
`define CAP_PIN_W 64
`define CAP_PIN_RST 64'h0

`endif

// ==== src/cap_pkg.sv ====
// Types shared by both ends of the command link
package cap_pkg;
  typedef enum logic [3:0] {
    CAP_C_HDR = 4'b0000,
    CAP_C_LEN = 4'b0001,
    CAP_C_DATA = 4'b0010,
    CAP_C_CHK = 4'b0011,
    CAP_C_AWAIT = 4'b0100,
    CAP_C_PWAIT = 4'b0101,
    CAP_C_TAG = 4'b0110,
    CAP_C_SIG = 4'b0111,
    CAP_C_SW1 = 4'b1000,
    CAP_C_SW2 = 4'b1001
  } cap_card_st_t;

  typedef enum logic [2:0] {
    CAP_T_IDLE = 3'b000,
    CAP_T_HDR = 3'b001,
    CAP_T_LC = 3'b010,
    CAP_T_DATA = 3'b011,
    CAP_T_LE = 3'b100,
    CAP_T_RSP = 3'b101
  } cap_term_st_t;

  typedef logic [7:0] cap_byte_t;
  typedef logic [15:0] cap_sw_t;
endpackage : cap_pkg

// ==== src/cap_link_if.sv ====
// Byte link between terminal and card: command stream and response stream
`timescale 1ns/100ps
`default_nettype none
interface cap_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_data;
  logic cmd_last;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;

  modport card (
    input cmd_valid, cmd_data, cmd_last, rsp_ready,
    output cmd_ready, rsp_valid, rsp_data, rsp_last
  );
  modport term (
    output cmd_valid, cmd_data, cmd_last, rsp_ready,
    input cmd_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface : cap_link_if
`default_nettype wire

// ==== src/cap_card.sv ====
// Card end: decodes authentication and PIN change/unblock commands
`timescale 1ns/100ps
`default_nettype none
`include "cap_consts.svh"

module cap_card (
  input wire logic i_clk,
  input wire logic i_rst_n,
  cap_link_if.card link,
  output logic o_dat_valid,
  output cap_pkg::cap_byte_t o_dat_byte,
  output logic o_auth_req,
  output logic o_pin_req,
  output cap_pkg::cap_byte_t o_mode,
  input wire logic i_auth_done,
  input wire cap_pkg::cap_sw_t i_auth_sw,
  input wire logic i_fmt2,
  input wire cap_pkg::cap_byte_t i_sig_len,
  input wire logic i_sig_valid,
  input wire cap_pkg::cap_byte_t i_sig_data,
  output logic o_sig_ready,
  input wire logic i_pin_done,
  input wire cap_pkg::cap_sw_t i_pin_sw,
  input wire logic [`CAP_PIN_W-1:0] i_new_pin,
  input wire logic [`CAP_PTC_W-1:0] i_ptc_limit,
  output logic [`CAP_PTC_W-1:0] o_ptc,
  output logic [`CAP_PIN_W-1:0] o_ref_pin
);
  import cap_pkg::*;

  cap_card_st_t state_reg, state_next;
  logic [1:0] idx_reg, idx_next;
  cap_byte_t cla_reg, cla_next, ins_reg, ins_next, p1_reg, p1_next, p2_reg, p2_next;
  cap_byte_t lc_reg, lc_next, cnt_reg, cnt_next, len_reg, len_next, out_reg, out_next;
  logic le_reg, le_next, fmt2_reg, fmt2_next;
  cap_sw_t sw_reg, sw_next;
  logic [`CAP_PTC_W-1:0] ptc_reg, ptc_next;
  logic [`CAP_PIN_W-1:0] pin_reg, pin_next;
  logic dat_valid_reg, dat_valid_next;
  cap_byte_t dat_reg, dat_next;

  // Header and length screening ahead of any computation
  function automatic cap_sw_t check_cmd(input cap_byte_t cla, input cap_byte_t ins,
                                        input cap_byte_t p1, input cap_byte_t p2,
                                        input cap_byte_t lc, input logic le);
    cap_sw_t sw;
    sw = `CAP_SW_OK;
    if (ins == `CAP_INS_AUTH) begin
      if (cla != `CAP_CLA_PLAIN) begin
        sw = (cla[`CAP_SM_BITS_HI:`CAP_SM_BITS_LO] != 2'b00) ? `CAP_SW_SM_UNSUP : `CAP_SW_BAD_CLA;
      end else if (p1 != `CAP_P_ZERO || p2 != `CAP_P_ZERO) begin
        sw = `CAP_SW_BAD_P1P2;
      end else if (!le) begin
        sw = `CAP_SW_NO_LE;
      end else if (lc == 8'h00) begin
        sw = `CAP_SW_BAD_DATA;
      end
    end else if (ins == `CAP_INS_PIN) begin
      if (cla != `CAP_CLA_SM_MAC && cla != `CAP_CLA_SM_ALT) begin
        sw = (cla == `CAP_CLA_PLAIN) ? `CAP_SW_SM_MISSING : `CAP_SW_BAD_CLA;
      end else if (p1 != `CAP_P_ZERO || p2 > `CAP_P2_PIN_MAX) begin
        sw = `CAP_SW_BAD_P1P2;
      end else if (le) begin
        sw = `CAP_SW_SM_WRONG;
      end else if (lc == 8'h00) begin
        sw = `CAP_SW_SM_MISSING;
      end
    end else begin
      sw = `CAP_SW_BAD_INS;
    end
    return sw;
  endfunction : check_cmd

  function automatic logic sw_success(input cap_sw_t sw);
    return (sw == `CAP_SW_OK) || (sw[15:8] == `CAP_SW1_WARN);
  endfunction : sw_success

  // Tag/length bytes ahead of the signed data; short length form only
  function automatic cap_byte_t tag_byte(input logic fmt2, input logic [1:0] i,
                                         input cap_byte_t len);
    cap_byte_t b;
    b = len;
    if (fmt2) begin
      case (i)
        2'd0: b = `CAP_TAG_CONS;
        2'd1: b = len + `CAP_TAG_HDR_LEN;
        2'd2: b = `CAP_TAG_PRIM;
        default: b = len;
      endcase
    end else if (i == 2'd0) begin
      b = `CAP_TAG_PRIM;
    end
    return b;
  endfunction : tag_byte

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    cla_next = cla_reg;
    ins_next = ins_reg;
    p1_next = p1_reg;
    p2_next = p2_reg;
    lc_next = lc_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    out_next = out_reg;
    le_next = le_reg;
    fmt2_next = fmt2_reg;
    sw_next = sw_reg;
    ptc_next = ptc_reg;
    pin_next = pin_reg;
    dat_valid_next = 1'b0;
    dat_next = dat_reg;
    case (state_reg)
      CAP_C_HDR: begin
        if (link.cmd_valid) begin
          case (idx_reg)
            2'd0: cla_next = link.cmd_data;
            2'd1: ins_next = link.cmd_data;
            2'd2: p1_next = link.cmd_data;
            default: p2_next = link.cmd_data;
          endcase
          idx_next = idx_reg + 2'd1;
          if (idx_reg == 2'd3) begin
            lc_next = 8'h00;
            le_next = 1'b0;
            cnt_next = 8'h00;
            state_next = link.cmd_last ? CAP_C_CHK : CAP_C_LEN;
          end
        end
      end
      CAP_C_LEN: begin
        if (link.cmd_valid) begin
          if (link.cmd_last) begin
            le_next = 1'b1;
            state_next = CAP_C_CHK;
          end else begin
            lc_next = link.cmd_data;
            state_next = CAP_C_DATA;
          end
        end
      end
      CAP_C_DATA: begin
        if (link.cmd_valid) begin
          if (cnt_reg == lc_reg) begin
            le_next = 1'b1;
          end else begin
            // Data goes to the key/MAC engine as it arrives; nothing acts on it yet
            dat_valid_next = 1'b1;
            dat_next = link.cmd_data;
            cnt_next = cnt_reg + 8'h01;
          end
          if (link.cmd_last) begin
            state_next = CAP_C_CHK;
          end
        end
      end
      CAP_C_CHK: begin
        sw_next = check_cmd(cla_reg, ins_reg, p1_reg, p2_reg, lc_reg, le_reg);
        if (sw_next != `CAP_SW_OK) begin
          out_next = sw_next[15:8];
          state_next = CAP_C_SW1;
        end else if (ins_reg == `CAP_INS_AUTH) begin
          state_next = CAP_C_AWAIT;
        end else begin
          state_next = CAP_C_PWAIT;
        end
      end
      CAP_C_AWAIT: begin
        if (i_auth_done) begin
          sw_next = i_auth_sw;
          len_next = i_sig_len;
          fmt2_next = i_fmt2;
          idx_next = 2'd0;
          cnt_next = 8'h00;
          if (sw_success(i_auth_sw)) begin
            out_next = tag_byte(i_fmt2, 2'd0, i_sig_len);
            state_next = CAP_C_TAG;
          end else begin
            out_next = i_auth_sw[15:8];
            state_next = CAP_C_SW1;
          end
        end
      end
      CAP_C_PWAIT: begin
        if (i_pin_done) begin
          sw_next = i_pin_sw;
          out_next = i_pin_sw[15:8];
          state_next = CAP_C_SW1;
          if (sw_success(i_pin_sw)) begin
            ptc_next = i_ptc_limit;
            if (p2_reg != `CAP_P_ZERO) begin
              pin_next = i_new_pin;
            end
          end
          // Any error status leaves counter and PIN as they were
        end
      end
      CAP_C_TAG: begin
        if (link.rsp_ready) begin
          idx_next = idx_reg + 2'd1;
          out_next = tag_byte(fmt2_reg, idx_reg + 2'd1, len_reg);
          if (idx_reg == (fmt2_reg ? 2'd3 : 2'd1)) begin
            if (len_reg == 8'h00) begin
              out_next = sw_reg[15:8];
              state_next = CAP_C_SW1;
            end else begin
              state_next = CAP_C_SIG;
            end
          end
        end
      end
      CAP_C_SIG: begin
        if (link.rsp_ready && i_sig_valid) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == len_reg - 8'h01) begin
            out_next = sw_reg[15:8];
            state_next = CAP_C_SW1;
          end
        end
      end
      CAP_C_SW1: begin
        if (link.rsp_ready) begin
          out_next = sw_reg[7:0];
          state_next = CAP_C_SW2;
        end
      end
      CAP_C_SW2: begin
        if (link.rsp_ready) begin
          idx_next = 2'd0;
          state_next = CAP_C_HDR;
        end
      end
      default: state_next = CAP_C_HDR;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= CAP_C_HDR;
      idx_reg <= 2'd0;
      cla_reg <= 8'h00;
      ins_reg <= 8'h00;
      p1_reg <= 8'h00;
      p2_reg <= 8'h00;
      lc_reg <= 8'h00;
      cnt_reg <= 8'h00;
      len_reg <= 8'h00;
      out_reg <= 8'h00;
      le_reg <= 1'b0;
      fmt2_reg <= 1'b0;
      sw_reg <= `CAP_SW_OK;
      ptc_reg <= `CAP_PTC_RST;
      pin_reg <= `CAP_PIN_RST;
      dat_valid_reg <= 1'b0;
      dat_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cla_reg <= cla_next;
      ins_reg <= ins_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      lc_reg <= lc_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      out_reg <= out_next;
      le_reg <= le_next;
      fmt2_reg <= fmt2_next;
      sw_reg <= sw_next;
      ptc_reg <= ptc_next;
      pin_reg <= pin_next;
      dat_valid_reg <= dat_valid_next;
      dat_reg <= dat_next;
    end
  end

  assign link.cmd_ready = (state_reg == CAP_C_HDR) || (state_reg == CAP_C_LEN) ||
                          (state_reg == CAP_C_DATA);
  // Signed data streams straight through to avoid a buffer the size of a signature
  assign link.rsp_valid = (state_reg == CAP_C_SIG) ? i_sig_valid :
                          (state_reg == CAP_C_TAG) || (state_reg == CAP_C_SW1) ||
                          (state_reg == CAP_C_SW2);
  assign link.rsp_data = (state_reg == CAP_C_SIG) ? i_sig_data : out_reg;
  assign link.rsp_last = (state_reg == CAP_C_SW2);
  assign o_sig_ready = (state_reg == CAP_C_SIG) && link.rsp_ready;
  assign o_auth_req = (state_reg == CAP_C_AWAIT);
  assign o_pin_req = (state_reg == CAP_C_PWAIT);
  assign o_mode = p2_reg;
  assign o_dat_valid = dat_valid_reg;
  assign o_dat_byte = dat_reg;
  assign o_ptc = ptc_reg;
  assign o_ref_pin = pin_reg;
endmodule : cap_card
`default_nettype wire

// ==== src/cap_term.sv ====
// Terminal end: frames one command and collects the card's response
`timescale 1ns/100ps
`default_nettype none
`include "cap_consts.svh"

module cap_term (
  input wire logic i_clk,
  input wire logic i_rst_n,
  cap_link_if.term link,
  input wire logic i_start,
  input wire cap_pkg::cap_byte_t i_cla,
  input wire cap_pkg::cap_byte_t i_ins,
  input wire cap_pkg::cap_byte_t i_p1,
  input wire cap_pkg::cap_byte_t i_p2,
  input wire cap_pkg::cap_byte_t i_lc,
  input wire logic i_le_present,
  input wire logic i_dat_valid,
  input wire cap_pkg::cap_byte_t i_dat_byte,
  output logic o_dat_ready,
  output logic o_busy,
  output logic o_rbyte_valid,
  output cap_pkg::cap_byte_t o_rbyte,
  output logic o_rbyte_last,
  output logic o_done,
  output cap_pkg::cap_sw_t o_sw
);
  import cap_pkg::*;

  cap_term_st_t state_reg, state_next;
  logic [1:0] idx_reg, idx_next;
  cap_byte_t hdr_reg [0:3];
  cap_byte_t hdr_next [0:3];
  cap_byte_t lc_reg, lc_next, cnt_reg, cnt_next, rb_reg, rb_next;
  logic le_reg, le_next, rv_reg, rv_next, rl_reg, rl_next, done_reg, done_next;
  cap_sw_t sw_reg, sw_next;

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    hdr_next = hdr_reg;
    lc_next = lc_reg;
    cnt_next = cnt_reg;
    le_next = le_reg;
    sw_next = sw_reg;
    rb_next = rb_reg;
    rv_next = 1'b0;
    rl_next = 1'b0;
    done_next = 1'b0;
    case (state_reg)
      CAP_T_IDLE: begin
        if (i_start) begin
          // Caller supplies CLA/INS/P1/P2/Lc/Le per command
          hdr_next[0] = i_cla;
          hdr_next[1] = i_ins;
          hdr_next[2] = i_p1;
          hdr_next[3] = i_p2;
          lc_next = i_lc;
          le_next = i_le_present;
          idx_next = 2'd0;
          cnt_next = 8'h00;
          state_next = CAP_T_HDR;
        end
      end
      CAP_T_HDR: begin
        if (link.cmd_ready) begin
          idx_next = idx_reg + 2'd1;
          if (idx_reg == 2'd3) begin
            state_next = (lc_reg == 8'h00 && !le_reg) ? CAP_T_RSP : CAP_T_LC;
          end
        end
      end
      CAP_T_LC: begin
        if (link.cmd_ready) begin
          state_next = (lc_reg == 8'h00) ? CAP_T_RSP : CAP_T_DATA;
        end
      end
      CAP_T_DATA: begin
        if (link.cmd_ready && i_dat_valid) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == lc_reg - 8'h01) begin
            state_next = le_reg ? CAP_T_LE : CAP_T_RSP;
          end
        end
      end
      CAP_T_LE: begin
        if (link.cmd_ready) begin
          state_next = CAP_T_RSP;
        end
      end
      CAP_T_RSP: begin
        if (link.rsp_valid) begin
          rv_next = 1'b1;
          rb_next = link.rsp_data;
          rl_next = link.rsp_last;
          sw_next = {sw_reg[7:0], link.rsp_data};
          if (link.rsp_last) begin
            done_next = 1'b1;
            state_next = CAP_T_IDLE;
          end
        end
      end
      default: state_next = CAP_T_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= CAP_T_IDLE;
      idx_reg <= 2'd0;
      for (int i = 0; i < 4; i++) begin
        hdr_reg[i] <= 8'h00;
      end
      lc_reg <= 8'h00;
      cnt_reg <= 8'h00;
      le_reg <= 1'b0;
      sw_reg <= 16'h0000;
      rb_reg <= 8'h00;
      rv_reg <= 1'b0;
      rl_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      hdr_reg <= hdr_next;
      lc_reg <= lc_next;
      cnt_reg <= cnt_next;
      le_reg <= le_next;
      sw_reg <= sw_next;
      rb_reg <= rb_next;
      rv_reg <= rv_next;
      rl_reg <= rl_next;
      done_reg <= done_next;
    end
  end

  // Lc byte doubles as the lone Le when there is no data field
  always_comb begin
    link.cmd_valid = 1'b0;
    link.cmd_data = 8'h00;
    link.cmd_last = 1'b0;
    case (state_reg)
      CAP_T_HDR: begin
        link.cmd_valid = 1'b1;
        link.cmd_data = hdr_reg[idx_reg];
        link.cmd_last = (idx_reg == 2'd3) && (lc_reg == 8'h00) && !le_reg;
      end
      CAP_T_LC: begin
        link.cmd_valid = 1'b1;
        link.cmd_data = (lc_reg == 8'h00) ? `CAP_LE_VALUE : lc_reg;
        link.cmd_last = (lc_reg == 8'h00);
      end
      CAP_T_DATA: begin
        // Enciphered PIN block first, MAC after, in caller order
        link.cmd_valid = i_dat_valid;
        link.cmd_data = i_dat_byte;
        link.cmd_last = (cnt_reg == lc_reg - 8'h01) && !le_reg;
      end
      CAP_T_LE: begin
        link.cmd_valid = 1'b1;
        link.cmd_data = `CAP_LE_VALUE;
        link.cmd_last = 1'b1;
      end
      default: begin
        link.cmd_valid = 1'b0;
      end
    endcase
  end

  assign o_dat_ready = (state_reg == CAP_T_DATA) && link.cmd_ready;
  assign link.rsp_ready = (state_reg == CAP_T_RSP);
  assign o_busy = (state_reg != CAP_T_IDLE);
  assign o_rbyte_valid = rv_reg;
  assign o_rbyte = rb_reg;
  assign o_rbyte_last = rl_reg;
  assign o_done = done_reg;
  assign o_sw = sw_reg;
endmodule : cap_term
`default_nettype wire

// ==== verif/cap_link_assertions.sv ====
// Checker for the command and response byte streams of the link
`timescale 1ns/100ps
`default_nettype none
module cap_link_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  logic [7:0] ccnt;
  logic [7:0] rcnt;
  logic [7:0] ins_r;
  logic [7:0] first_r;
  logic tk_c;
  logic tk_r;
  assign tk_c = cmd_valid && cmd_ready;
  assign tk_r = rsp_valid && rsp_ready;

  // Byte counts restart once SW2 is taken
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ccnt <= 8'h0;
      rcnt <= 8'h0;
      ins_r <= 8'h0;
      first_r <= 8'h0;
    end else begin
      if (tk_c) ccnt <= ccnt + 8'h1;
      if (tk_c && ccnt == 8'h1) ins_r <= cmd_data;
      if (tk_r) rcnt <= rsp_last ? 8'h0 : rcnt + 8'h1;
      if (tk_r && rcnt == 8'h0) first_r <= rsp_data;
      if (tk_r && rsp_last) ccnt <= 8'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_cmd_held: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("command byte changed before it was taken");
  a_rsp_held: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("response byte changed before it was taken");
  a_no_cmd_rsp: assert property (rsp_valid |-> !cmd_ready)
    else $error("card accepts command bytes while answering");
  a_last_stops: assert property (tk_c && cmd_last |=> !cmd_ready && !cmd_valid)
    else $error("command bytes continue after the last one");
  a_bad_ins_fast: assert property (tk_c && cmd_last && !(ins_r inside {8'h88, 8'h24})
    |-> ##[1:4] (rsp_valid && rsp_data == 8'h6d))
    else $error("unknown instruction not refused promptly");
  a_pin_sw_only: assert property (tk_r && rsp_last && ins_r == 8'h24 |-> rcnt == 8'h1)
    else $error("PIN command answered with data bytes");
  a_auth_tag: assert property (rsp_valid && rcnt == 8'h0 && ins_r == 8'h88
    |-> rsp_data inside {8'h80, 8'h79, 8'h64, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6e})
    else $error("authentication answer opens with a wrong byte");
  a_fmt2_inner: assert property (rsp_valid && rcnt == 8'h2 && first_r == 8'h79
    && ins_r == 8'h88 |-> rsp_data == 8'h80)
    else $error("constructed answer lacks the inner signature object");
  a_ready_again: assert property (tk_r && rsp_last |=> cmd_ready)
    else $error("card not ready for a new command after SW2");

  c_fmt2: cover property (rsp_valid && rcnt == 8'h2 && first_r == 8'h79);
  c_pin_done: cover property (tk_r && rsp_last && ins_r == 8'h24);
  c_auth_cmd: cover property (tk_c && cmd_last && ins_r == 8'h88);
endmodule : cap_link_checker
`default_nettype wire

// ==== verif/card_auth_pin_apdu_handler_tb.sv ====
// Bench joining terminal and card ends, with engine stand-ins on the card
`timescale 1ns/100ps
`default_nettype none
module card_auth_pin_apdu_handler_tb;
  import cap_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic i_le_present = 1'b0;
  logic i_dat_valid = 1'b0;
  cap_byte_t i_cla = 8'h0, i_ins = 8'h0, i_p1 = 8'h0, i_p2 = 8'h0, i_lc = 8'h0;
  cap_byte_t i_dat_byte = 8'h0, i_sig_len = 8'h0, i_sig_data = 8'h0;
  logic i_auth_done = 1'b0, i_fmt2 = 1'b0, i_sig_valid = 1'b0, i_pin_done = 1'b0;
  cap_sw_t i_auth_sw = 16'h0, i_pin_sw = 16'h0;
  logic [63:0] i_new_pin = 64'h0;
  logic [3:0] i_ptc_limit = 4'h0;
  logic o_dat_ready, o_busy, o_rbyte_valid, o_rbyte_last, o_done;
  logic o_dat_valid, o_auth_req, o_pin_req, o_sig_ready;
  cap_byte_t o_rbyte, o_dat_byte, o_mode;
  cap_sw_t o_sw;
  logic [3:0] o_ptc;
  logic [63:0] o_ref_pin;
  int err_count = 0;
  int total_checks = 0;
  int n = 0;
  cap_byte_t rq[$];
  cap_byte_t dq[$];
  cap_byte_t lc_use = 8'h2;
  cap_byte_t last_b = 8'hff;
  logic [3:0] ptc_exp = 4'h3;
  logic [63:0] pin_exp = 64'h0;
  cap_sw_t aerr[3] = '{16'h6400, 16'h6985, 16'h6a80};
  cap_sw_t perr[8] = '{16'h6400, 16'h6581, 16'h6982, 16'h6984,
                       16'h6987, 16'h6988, 16'h6a86, 16'h6a88};
  // Header and length faults: cla ins p1 p2 lc le status
  logic [63:0] herr[11] = '{64'h0088010002016a86, 64'h0088000002006700, 64'h0c88000002016882,
    64'h8088000002016e00, 64'h0024000002006987, 64'h8c24010002006a86, 64'h8c24000302006a86,
    64'h8424000002016988, 64'h0088000000016a80, 64'h8c24000000006987, 64'h00c0000002016d00};

  cap_link_if cap_link_if_inst ();
  cap_term cap_term_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(cap_link_if_inst),
    .i_start(i_start), .i_cla(i_cla), .i_ins(i_ins), .i_p1(i_p1), .i_p2(i_p2), .i_lc(i_lc),
    .i_le_present(i_le_present), .i_dat_valid(i_dat_valid), .i_dat_byte(i_dat_byte),
    .o_dat_ready(o_dat_ready), .o_busy(o_busy), .o_rbyte_valid(o_rbyte_valid),
    .o_rbyte(o_rbyte), .o_rbyte_last(o_rbyte_last), .o_done(o_done), .o_sw(o_sw));
  cap_card cap_card_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(cap_link_if_inst),
    .o_dat_valid(o_dat_valid), .o_dat_byte(o_dat_byte), .o_auth_req(o_auth_req),
    .o_pin_req(o_pin_req), .o_mode(o_mode), .i_auth_done(i_auth_done),
    .i_auth_sw(i_auth_sw), .i_fmt2(i_fmt2), .i_sig_len(i_sig_len),
    .i_sig_valid(i_sig_valid), .i_sig_data(i_sig_data), .o_sig_ready(o_sig_ready),
    .i_pin_done(i_pin_done), .i_pin_sw(i_pin_sw), .i_new_pin(i_new_pin),
    .i_ptc_limit(i_ptc_limit), .o_ptc(o_ptc), .o_ref_pin(o_ref_pin));
  cap_link_checker cap_link_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .cmd_valid(cap_link_if_inst.cmd_valid), .cmd_ready(cap_link_if_inst.cmd_ready),
    .cmd_data(cap_link_if_inst.cmd_data), .cmd_last(cap_link_if_inst.cmd_last),
    .rsp_valid(cap_link_if_inst.rsp_valid), .rsp_ready(cap_link_if_inst.rsp_ready),
    .rsp_data(cap_link_if_inst.rsp_data), .rsp_last(cap_link_if_inst.rsp_last));

  always #50 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (o_rbyte_valid === 1'b1) rq.push_back(o_rbyte);
    if (o_dat_valid === 1'b1) dq.push_back(o_dat_byte);
    if (o_rbyte_last === 1'b1) last_b = o_rbyte;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // One whole command; the bench plays the card's engines when asked
  task automatic run(input cap_byte_t cla, input cap_byte_t ins, input cap_byte_t p1,
      input cap_byte_t p2, input logic le, input logic eng, input cap_sw_t sw,
      input logic f2, input cap_byte_t sl);
    cap_byte_t eq[$];
    logic ok;
    ok = eng && (sw == 16'h9000 || sw[15:8] == 8'h62);
    rq = {};
    dq = {};
    last_b = 8'hff;
    n++;
    i_cla <= cla;
    i_ins <= ins;
    i_p1 <= p1;
    i_p2 <= p2;
    i_lc <= lc_use;
    i_le_present <= le;
    i_start <= 1'b1;
    i_new_pin <= 64'h5a5a_0000_0000_0000 + 64'(n);
    i_ptc_limit <= 4'(n + 4);
    @(posedge i_clk);
    i_start <= 1'b0;
    for (int k = 0; k < lc_use; k++) begin
      i_dat_valid <= 1'b1;
      i_dat_byte <= 8'h30 + 8'(k);
      do @(posedge i_clk); while (o_dat_ready !== 1'b1);
    end
    i_dat_valid <= 1'b0;
    while (!(o_pin_req === 1'b1 || o_auth_req === 1'b1 || o_done === 1'b1)) @(posedge i_clk);
    check(64'(o_auth_req | o_pin_req), 64'(eng));
    if (o_pin_req === 1'b1) begin
      check(64'(o_mode), 64'(p2));
      i_pin_done <= 1'b1;
      i_pin_sw <= sw;
      @(posedge i_clk);
      i_pin_done <= 1'b0;
    end
    if (o_auth_req === 1'b1) begin
      i_auth_done <= 1'b1;
      i_auth_sw <= sw;
      i_fmt2 <= f2;
      i_sig_len <= sl;
      @(posedge i_clk);
      i_auth_done <= 1'b0;
      for (int k = 0; ok && k < sl; k++) begin
        i_sig_valid <= 1'b1;
        i_sig_data <= 8'hc0 + 8'(k);
        do @(posedge i_clk); while (o_sig_ready !== 1'b1);
      end
      i_sig_valid <= 1'b0;
    end
    while (o_done !== 1'b1) @(posedge i_clk);
    @(posedge i_clk);
    if (ok && ins == 8'h88) begin
      if (f2) eq = {8'h79, sl + 8'h2};
      eq.push_back(8'h80);
      eq.push_back(sl);
      for (int k = 0; k < sl; k++) eq.push_back(8'hc0 + 8'(k));
    end
    eq.push_back(sw[15:8]);
    eq.push_back(sw[7:0]);
    check(64'(rq.size()), 64'(eq.size()));
    foreach (eq[i]) check(64'(rq[i]), 64'(eq[i]));
    check(64'(o_sw), 64'(sw));
    check(64'(last_b), 64'(sw[7:0]));
    check(64'(o_busy), 64'h0);
    if (eng) check(64'({dq[0], dq[1]}), 64'h3031);
    if (ok && ins == 8'h24) begin
      ptc_exp = 4'(n + 4);
      if (p2 != 8'h0) pin_exp = 64'h5a5a_0000_0000_0000 + 64'(n);
    end
    check(64'(o_ptc), 64'(ptc_exp));
    check(o_ref_pin, pin_exp);
  endtask : run

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    check(64'(o_ptc), 64'h3);
    run(8'h00, 8'h88, 8'h0, 8'h0, 1'b1, 1'b1, 16'h9000, 1'b0, 8'h3);
    run(8'h00, 8'h88, 8'h0, 8'h0, 1'b1, 1'b1, 16'h6281, 1'b1, 8'h2);
    foreach (aerr[i]) run(8'h00, 8'h88, 8'h0, 8'h0, 1'b1, 1'b1, aerr[i], 1'b0, 8'h2);
    foreach (herr[i]) begin
      // Lc of zero reaches the lone Le and header-only framings
      lc_use = herr[i][31:24];
      run(herr[i][63:56], herr[i][55:48], herr[i][47:40], herr[i][39:32],
        herr[i][16], 1'b0, herr[i][15:0], 1'b0, 8'h0);
    end
    lc_use = 8'h2;
    run(8'h8c, 8'h24, 8'h0, 8'h0, 1'b0, 1'b1, 16'h9000, 1'b0, 8'h0);
    run(8'h84, 8'h24, 8'h0, 8'h1, 1'b0, 1'b1, 16'h6200, 1'b0, 8'h0);
    run(8'h8c, 8'h24, 8'h0, 8'h2, 1'b0, 1'b1, 16'h6281, 1'b0, 8'h0);
    foreach (perr[i]) run(8'h8c, 8'h24, 8'h0, 8'h2, 1'b0, 1'b1, perr[i], 1'b0, 8'h0);
    run(8'h8c, 8'h24, 8'h0, 8'h1, 1'b0, 1'b1, 16'h9000, 1'b0, 8'h0);
    results();
  end

  // About 28 commands of under 40 cycles each; this span is ample
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    results();
  end
endmodule : card_auth_pin_apdu_handler_tb
`default_nettype wire
